// *** logic/pmpl_pkg.sv ***
// pmpl_pkg.sv: constants and types for the per-port mii logic block
package pmpl_pkg;
	// register map over the plain register port
	localparam logic [3:0] PMPL_ADDR_CTRL   = 4'h0;
	localparam logic [3:0] PMPL_ADDR_STATUS = 4'h1;
	localparam logic [3:0] PMPL_ADDR_CFG    = 4'h2;
	localparam logic [3:0] PMPL_ADDR_XOVER  = 4'h3;
	// control register bits
	localparam int PMPL_CTRL_LOOP   = 14;
	localparam int PMPL_CTRL_ANEG   = 12;
	localparam int PMPL_CTRL_DUPLEX = 8;
	localparam int PMPL_CTRL_SPEED  = 13;
	// config and crossover register bits, register reset values
	localparam int PMPL_CFG_FIBER   = 0;
	localparam int PMPL_CFG_NOECHO  = 8;
	localparam int PMPL_XOVER_LO    = 8;
	localparam logic [1:0]  PMPL_XOVER_AUTO = 2'h2;
	localparam logic [15:0] PMPL_CTRL_RST   = 16'h1000;
	localparam logic [15:0] PMPL_CFG_RST    = 16'h0000;
	// line symbols exchanged with the coding layer
	localparam logic [3:0] PMPL_NIB_ERR = 4'he;
	localparam logic [3:0] PMPL_NIB_SFD = 4'hd;
	localparam logic [3:0] PMPL_NIB_PRE = 4'h5;
	// clock timing
	localparam int PMPL_SYS_MHZ    = 100;
	localparam int PMPL_FAST_MHZ10 = 250;
	localparam int PMPL_SLOW_MHZ10 = 25;
	localparam int PMPL_HALF_FAST =
		PMPL_SYS_MHZ * 10 / PMPL_FAST_MHZ10 / 2;
	localparam int PMPL_HALF_SLOW =
		PMPL_SYS_MHZ * 10 / PMPL_SLOW_MHZ10 / 2;
	localparam int PMPL_NLP_US   = 16000;
	localparam int PMPL_NLP_CYC  = PMPL_NLP_US * PMPL_SYS_MHZ / 1000;
	localparam int PMPL_DET_CYC  = 1000;

	typedef enum logic [2:0] {
		PMPL_SYM_IDLE, PMPL_SYM_JK, PMPL_SYM_DATA, PMPL_SYM_TR,
		PMPL_SYM_BAD, PMPL_SYM_H, PMPL_SYM_NLP, PMPL_SYM_FLP
	} pmpl_sym_e;

	typedef struct packed {
		logic       en;
		logic       er;
		logic [3:0] d;
	} pmpl_nib_s;

	typedef struct packed {
		pmpl_sym_e  sym;
		logic [3:0] d;
	} pmpl_line_s;

	typedef struct packed {
		logic up;
		logic fast;
		logic full;
		logic fiber;
		logic pdet;
	} pmpl_mode_s;
endpackage : pmpl_pkg

// *** logic/pmpl_clkgen.sv ***
// pmpl_clkgen.sv: mii clock divider with speed-dependent half period
`timescale 1ns/1ps
module pmpl_clkgen (
	input  wire logic CLOCK,
	input  wire logic RESETN,
	input  wire logic fast,
	output logic      mii_clk,
	output logic      rise
);
	logic [7:0] cnt_r;
	logic [7:0] half;
	assign half = fast ? 8'(pmpl_pkg::PMPL_HALF_FAST)
		: 8'(pmpl_pkg::PMPL_HALF_SLOW);

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			cnt_r   <= 8'h00;
			mii_clk <= 1'b0;
		end else if (cnt_r >= half - 8'h01) begin
			cnt_r   <= 8'h00;
			mii_clk <= ~mii_clk;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
	assign rise = (cnt_r >= half - 8'h01) && !mii_clk;
endmodule : pmpl_clkgen

// *** logic/pmpl_sync.sv ***
// pmpl_sync.sv: two-flop synchroniser for a bus of levels
`timescale 1ns/1ps
module pmpl_sync #(
	parameter int W = 1
) (
	input  wire logic         CLOCK,
	input  wire logic         RESETN,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] m_r;
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			m_r <= '0;
			q   <= '0;
		end else begin
			m_r <= d;
			q   <= m_r;
		end
	end
endmodule : pmpl_sync

// *** logic/pmpl_port.sv ***
// pmpl_port.sv: one phy port's mii, mode, loopback and line framing logic
`timescale 1ns/1ps
module pmpl_port (
	input  wire logic                 CLOCK,
	input  wire logic                 RESETN,
	// strap pins
	input  wire logic                 HW_MODE,
	input  wire logic                 HW_SPEED_SELECT,
	input  wire logic                 HW_DUPLEX_SELECT,
	input  wire logic                 HW_MEDIA_SELECT,
	// register port
	input  wire logic [3:0]           REG_ADDR,
	input  wire logic [15:0]          REG_WDATA,
	input  wire logic                 REG_WR,
	input  wire logic                 REG_RD,
	output logic      [15:0]          REG_RDATA,
	// mii
	output logic                      TX_CLK,
	output logic                      RX_CLK,
	input  wire logic                 TX_EN,
	input  wire logic                 TX_ER,
	input  wire logic [3:0]           TXD,
	output logic                      RX_DV,
	output logic                      RX_ER,
	output logic      [3:0]           RXD,
	output logic                      CRS,
	output logic                      COL,
	// coded line side
	input  wire pmpl_pkg::pmpl_line_s LINE_IN,
	input  wire logic                 PARTNER_ANEG,
	input  wire logic                 PARTNER_FULL,
	output pmpl_pkg::pmpl_line_s      LINE_OUT_PAIR,
	output logic                      LINE_OE,
	output logic                      MDIX_MODE_AUTO
);
	////////////////////////////////////////////////////////////////////
	// clocks and synchronisers
	logic      tx_rise;
	logic      rx_rise;
	logic      txck;
	logic [5:0] tx_s;
	logic [3:0] strap_s;
	pmpl_pkg::pmpl_mode_s mode_r;
	pmpl_pkg::pmpl_mode_s mode_nxt;

	pmpl_clkgen u_clk (
		.CLOCK   (CLOCK),
		.RESETN  (RESETN),
		.fast    (mode_r.fast),
		.mii_clk (txck),
		.rise    (tx_rise)
	);
	assign TX_CLK  = txck;
	assign RX_CLK  = txck;
	assign rx_rise = tx_rise;

	// mac drives on tx clock; one tx clock is many system clocks so the
	// synchroniser settles before the sampling edge
	pmpl_sync #(.W(6)) u_txs (
		.CLOCK  (CLOCK),
		.RESETN (RESETN),
		.d      ({TX_EN, TX_ER, TXD}),
		.q      (tx_s)
	);
	pmpl_sync #(.W(4)) u_strap (
		.CLOCK  (CLOCK),
		.RESETN (RESETN),
		.d      ({HW_MODE, HW_SPEED_SELECT, HW_DUPLEX_SELECT,
			HW_MEDIA_SELECT}),
		.q      (strap_s)
	);

	pmpl_pkg::pmpl_nib_s tx_r;
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN)
			tx_r <= '0;
		else if (tx_rise)
			tx_r <= {tx_s[5], tx_s[4], tx_s[3:0]};
	end

	////////////////////////////////////////////////////////////////////
	// registers
	logic [15:0] ctrl_r;
	logic [15:0] cfg_r;
	logic [1:0]  xover_r;
	logic        test_lb;

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			ctrl_r  <= pmpl_pkg::PMPL_CTRL_RST;
			cfg_r   <= pmpl_pkg::PMPL_CFG_RST;
			xover_r <= pmpl_pkg::PMPL_XOVER_AUTO;
		end else if (REG_WR) begin
			case (REG_ADDR)
			pmpl_pkg::PMPL_ADDR_CTRL:  ctrl_r <= REG_WDATA;
			pmpl_pkg::PMPL_ADDR_CFG:   cfg_r  <= REG_WDATA;
			pmpl_pkg::PMPL_ADDR_XOVER:
				xover_r <= REG_WDATA[pmpl_pkg::PMPL_XOVER_LO +: 2];
			default: ;
			endcase
		end
	end
	assign MDIX_MODE_AUTO = xover_r[1];

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN)
			REG_RDATA <= 16'h0000;
		else if (REG_RD) begin
			case (REG_ADDR)
			pmpl_pkg::PMPL_ADDR_CTRL:   REG_RDATA <= ctrl_r;
			pmpl_pkg::PMPL_ADDR_CFG:    REG_RDATA <= cfg_r;
			pmpl_pkg::PMPL_ADDR_XOVER:
				REG_RDATA <= {6'h00, xover_r, 8'h00};
			pmpl_pkg::PMPL_ADDR_STATUS:
				REG_RDATA <= {11'h000, mode_r};
			default:                    REG_RDATA <= 16'h0000;
			endcase
		end else
			REG_RDATA <= 16'h0000;
	end

	assign test_lb = ctrl_r[pmpl_pkg::PMPL_CTRL_LOOP]
		&& ctrl_r[pmpl_pkg::PMPL_CTRL_DUPLEX]
		&& !ctrl_r[pmpl_pkg::PMPL_CTRL_ANEG];

	////////////////////////////////////////////////////////////////////
	// mode selection
	logic        strapped_r;
	logic        hw_r;
	logic [15:0] det_r;
	logic        aneg_on;
	assign aneg_on = !hw_r && ctrl_r[pmpl_pkg::PMPL_CTRL_ANEG];

	// mode strap caught by a clocked process once the synchroniser is full
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			strapped_r <= 1'b0;
			hw_r       <= 1'b0;
		end else if (!strapped_r && det_r == 16'h0002) begin
			strapped_r <= 1'b1;
			hw_r       <= strap_s[3];
		end
	end

	always_comb begin
		mode_nxt = mode_r;
		if (hw_r) begin
			mode_nxt.up    = 1'b1;
			mode_nxt.fast  = strap_s[2];
			mode_nxt.full  = strap_s[1];
			mode_nxt.fiber = !strap_s[0];
			mode_nxt.pdet  = 1'b0;
		end else if (!aneg_on) begin
			mode_nxt.up    = 1'b1;
			mode_nxt.fast  = ctrl_r[pmpl_pkg::PMPL_CTRL_SPEED];
			mode_nxt.full  = ctrl_r[pmpl_pkg::PMPL_CTRL_DUPLEX];
			mode_nxt.fiber = cfg_r[pmpl_pkg::PMPL_CFG_FIBER];
			mode_nxt.pdet  = 1'b0;
		end else if (det_r >= 16'(pmpl_pkg::PMPL_DET_CYC)) begin
			mode_nxt.up    = 1'b1;
			mode_nxt.fiber = cfg_r[pmpl_pkg::PMPL_CFG_FIBER];
			// negotiation result or parallel detection
			if (PARTNER_ANEG) begin
				mode_nxt.fast = 1'b1;
				mode_nxt.full = PARTNER_FULL;
				mode_nxt.pdet = 1'b0;
			end else begin
				mode_nxt.fast = (LINE_IN.sym == pmpl_pkg::PMPL_SYM_IDLE);
				mode_nxt.full = 1'b0;
				mode_nxt.pdet = 1'b1;
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			mode_r <= '0;
			det_r  <= 16'h0000;
		end else begin
			if (strapped_r)
				mode_r <= mode_nxt;
			if (det_r != 16'hffff)
				det_r <= det_r + 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////
	// transmit line
	logic [20:0] nlp_r;
	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN)
			nlp_r <= 21'h00_0000;
		else if (nlp_r >= 21'(pmpl_pkg::PMPL_NLP_CYC - 1))
			nlp_r <= 21'h00_0000;
		else
			nlp_r <= nlp_r + 21'h00_0001;
	end

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN)
			LINE_OUT_PAIR <= '{pmpl_pkg::PMPL_SYM_IDLE, 4'h0};
		else if (tx_r.en && tx_r.er)
			LINE_OUT_PAIR <= '{pmpl_pkg::PMPL_SYM_H, 4'h0};
		else if (tx_r.en)
			LINE_OUT_PAIR <= '{pmpl_pkg::PMPL_SYM_DATA, tx_r.d};
		else if (mode_r.fast)
			LINE_OUT_PAIR <= '{pmpl_pkg::PMPL_SYM_IDLE, 4'h0};
		else if (nlp_r == 21'h00_0000)
			LINE_OUT_PAIR <= '{pmpl_pkg::PMPL_SYM_NLP, 4'h0};
		else
			LINE_OUT_PAIR <= '{pmpl_pkg::PMPL_SYM_IDLE, 4'h0};
	end
	assign LINE_OE = !test_lb;

	////////////////////////////////////////////////////////////////////
	// receive framing
	logic rx_car_r;
	logic rx_dv_line_r;
	logic sfd_seen_r;
	logic lb_echo;
	logic line_act;
	assign lb_echo = !mode_r.fast && !mode_r.full
		&& !cfg_r[pmpl_pkg::PMPL_CFG_NOECHO] && !test_lb;

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			rx_car_r   <= 1'b0;
			sfd_seen_r <= 1'b0;
		end else if (test_lb) begin
			rx_car_r   <= 1'b0;
			sfd_seen_r <= 1'b0;
		end else if (mode_r.fast) begin
			sfd_seen_r <= 1'b0;
			case (LINE_IN.sym)
			pmpl_pkg::PMPL_SYM_JK:   rx_car_r <= 1'b1;
			pmpl_pkg::PMPL_SYM_TR:   rx_car_r <= 1'b0;
			pmpl_pkg::PMPL_SYM_IDLE: rx_car_r <= 1'b0;
			default: ;
			endcase
		end else if (LINE_IN.sym == pmpl_pkg::PMPL_SYM_DATA) begin
			if (LINE_IN.d == pmpl_pkg::PMPL_NIB_PRE)
				rx_car_r <= 1'b1;
			if (rx_car_r && LINE_IN.d == pmpl_pkg::PMPL_NIB_SFD)
				sfd_seen_r <= 1'b1;
		end else begin
			rx_car_r   <= 1'b0;
			sfd_seen_r <= 1'b0;
		end
	end
	assign line_act = rx_car_r;

	// receive outputs move only on the receive clock edge
	logic rx_car_d_r;
	logic idle_cut;
	assign idle_cut = mode_r.fast && rx_car_d_r && !rx_car_r
		&& LINE_IN.sym == pmpl_pkg::PMPL_SYM_IDLE;

	always_ff @(posedge CLOCK or negedge RESETN) begin
		if (!RESETN) begin
			RX_DV      <= 1'b0;
			RX_ER      <= 1'b0;
			RXD        <= 4'h0;
			rx_car_d_r <= 1'b0;
		end else if (rx_rise) begin
			rx_car_d_r <= rx_car_r;
			if (test_lb || (lb_echo && tx_r.en)) begin
				RX_DV <= tx_r.en;
				RX_ER <= tx_r.er;
				RXD   <= tx_r.d;
			end else if (idle_cut) begin
				RX_DV <= 1'b0;
				RX_ER <= 1'b1;
				RXD   <= 4'h0;
			end else if (mode_r.fast && rx_car_r
				&& LINE_IN.sym == pmpl_pkg::PMPL_SYM_BAD) begin
				RX_DV <= 1'b1;
				RX_ER <= 1'b1;
				RXD   <= pmpl_pkg::PMPL_NIB_ERR;
			end else if (mode_r.fast) begin
				RX_DV <= rx_car_r;
				RX_ER <= 1'b0;
				RXD   <= rx_car_r ? LINE_IN.d : 4'h0;
			end else begin
				RX_DV <= rx_car_r && (sfd_seen_r
					|| LINE_IN.d == pmpl_pkg::PMPL_NIB_SFD);
				RX_ER <= 1'b0;
				RXD   <= LINE_IN.d;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// carrier and collision, combinational from the active terms
	assign CRS = line_act || (tx_r.en && !mode_r.full);
	assign COL = !mode_r.full && line_act && tx_r.en;

	////////////////////////////////////////////////////////////////////
	// checks
	property p_lb_gate;
		@(posedge CLOCK) disable iff (!RESETN)
		!LINE_OE |-> ctrl_r[pmpl_pkg::PMPL_CTRL_LOOP]
			&& ctrl_r[pmpl_pkg::PMPL_CTRL_DUPLEX]
			&& !ctrl_r[pmpl_pkg::PMPL_CTRL_ANEG];
	endproperty
	a_lb_gate: assert property (p_lb_gate)
		else $error("test loopback without its control bits");

	property p_col;
		@(posedge CLOCK) disable iff (!RESETN)
		COL |-> !mode_r.full && tx_r.en && rx_car_r;
	endproperty
	a_col: assert property (p_col)
		else $error("collision without half duplex activity");

	property p_crs_full;
		@(posedge CLOCK) disable iff (!RESETN)
		mode_r.full && !rx_car_r |-> !CRS;
	endproperty
	a_crs_full: assert property (p_crs_full)
		else $error("carrier sense on full duplex transmit");

	property p_pdet_half;
		@(posedge CLOCK) disable iff (!RESETN)
		mode_r.pdet |-> !mode_r.full;
	endproperty
	a_pdet_half: assert property (p_pdet_half)
		else $error("parallel detect link not half duplex");

	property p_rx_sync;
		@(posedge CLOCK) disable iff (!RESETN)
		!$past(rx_rise) |-> $stable(RXD) && $stable(RX_DV);
	endproperty
	a_rx_sync: assert property (p_rx_sync)
		else $error("receive outputs moved off the clock edge");

	sequence s_bad_rx;
		rx_rise && mode_r.fast && rx_car_r && !test_lb && !lb_echo
			&& !idle_cut && LINE_IN.sym == pmpl_pkg::PMPL_SYM_BAD;
	endsequence
	property p_bad_sym;
		@(posedge CLOCK) disable iff (!RESETN)
		s_bad_rx |=> RX_ER && RXD == pmpl_pkg::PMPL_NIB_ERR;
	endproperty
	a_bad_sym: assert property (p_bad_sym)
		else $error("invalid symbol not flagged with 1110");

	property p_h_sym;
		@(posedge CLOCK) disable iff (!RESETN)
		tx_r.en && tx_r.er |=> LINE_OUT_PAIR.sym == pmpl_pkg::PMPL_SYM_H;
	endproperty
	a_h_sym: assert property (p_h_sym)
		else $error("tx error did not send h symbols");

	property p_idle_fast;
		@(posedge CLOCK) disable iff (!RESETN)
		mode_r.fast && !tx_r.en |=>
			LINE_OUT_PAIR.sym == pmpl_pkg::PMPL_SYM_IDLE;
	endproperty
	a_idle_fast: assert property (p_idle_fast)
		else $error("no idle symbols between frames at 100 Mbps");

	property p_er_pulse;
		@(posedge CLOCK) disable iff (!RESETN)
		rx_rise && idle_cut && !test_lb && !(lb_echo && tx_r.en) |=>
			RX_ER && !RX_DV;
	endproperty
	a_er_pulse: assert property (p_er_pulse)
		else $error("idle cut without receive error");
endmodule : pmpl_port

// *** tb/pmpl_mac_model.sv ***
// pmpl_mac_model.sv: behavioural mac on the far side of the mii
`timescale 1ns/1ps
module pmpl_mac_model (
	input  wire logic       TX_CLK,
	input  wire logic       RX_CLK,
	input  wire logic       RX_DV,
	input  wire logic       RX_ER,
	input  wire logic [3:0] RXD,
	output logic            TX_EN,
	output logic            TX_ER,
	output logic      [3:0] TXD
);
	logic [3:0] rx_q[$];
	int         n_rx_er = 0;
	logic [3:0] er_nib = 4'h0;

	initial begin
		TX_EN = 1'b0;
		TX_ER = 1'b0;
		TXD   = 4'h0;
	end

	// sampled mid-cycle: the port moves rx outputs in the rising-edge step
	always @(negedge RX_CLK) begin
		if (RX_DV === 1'b1) rx_q.push_back(RXD);
		if (RX_ER === 1'b1) begin
			if (n_rx_er == 0) er_nib = RXD;
			n_rx_er++;
		end
	end

	task automatic send(input logic [3:0] nib[$], input logic er);
		foreach (nib[i]) begin
			@(posedge TX_CLK);
			TX_EN <= 1'b1;
			TX_ER <= er;
			TXD   <= nib[i];
		end
		@(posedge TX_CLK);
		TX_EN <= 1'b0;
		TX_ER <= 1'b0;
		// released data must not keep showing the last nibble
		TXD   <= ~nib[nib.size() - 1];
	endtask : send
endmodule : pmpl_mac_model

// *** tb/testbench.sv ***
// testbench.sv: self-checking bench for one phy port's mii logic
`timescale 1ns/1ps
module testbench;
	logic                 clk = 1'b0;
	logic                 rst_n = 1'b0;
	logic [3:0]           strap = 4'b1111;
	logic [3:0]           reg_addr = 4'h0;
	logic [15:0]          reg_wdata = 16'h0000;
	logic                 reg_wr = 1'b0;
	logic                 reg_rd = 1'b0;
	logic [15:0]          reg_rdata;
	logic                 tx_clk, rx_clk, tx_en, tx_er, rx_dv, rx_er;
	logic                 crs, col, line_oe, mdix_auto;
	logic [3:0]           txd, rxd;
	pmpl_pkg::pmpl_line_s line_in = '{pmpl_pkg::PMPL_SYM_IDLE, 4'h0};
	pmpl_pkg::pmpl_line_s line_out;
	logic                 p_aneg = 1'b0;
	logic                 p_full = 1'b0;
	int                   n_errors = 0;
	int                   comparisons = 0;
	logic [3:0]           frm[$] = {4'h5, 4'h5, 4'h5, 4'hd, 4'ha, 4'h3, 4'hc};

	always #5 clk = ~clk;

	pmpl_port DUT (.CLOCK(clk), .RESETN(rst_n), .HW_MODE(strap[3]),
		.HW_SPEED_SELECT(strap[2]), .HW_DUPLEX_SELECT(strap[1]),
		.HW_MEDIA_SELECT(strap[0]), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_RDATA(reg_rdata), .TX_CLK(tx_clk), .RX_CLK(rx_clk),
		.TX_EN(tx_en), .TX_ER(tx_er), .TXD(txd), .RX_DV(rx_dv),
		.RX_ER(rx_er), .RXD(rxd), .CRS(crs), .COL(col),
		.LINE_IN(line_in), .PARTNER_ANEG(p_aneg), .PARTNER_FULL(p_full),
		.LINE_OUT_PAIR(line_out), .LINE_OE(line_oe),
		.MDIX_MODE_AUTO(mdix_auto));

	pmpl_mac_model mac (.TX_CLK(tx_clk), .RX_CLK(rx_clk), .RX_DV(rx_dv),
		.RX_ER(rx_er), .RXD(rxd), .TX_EN(tx_en), .TX_ER(tx_er), .TXD(txd));

	////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : close_out

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge clk);
		reg_wr    <= 1'b0;
	endtask : wr_reg

	task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge clk);
		reg_rd   <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd_reg

	// s holds {strap mode, speed, duplex, media}; only the mode strap is latched at boot
	task automatic boot(input logic [3:0] s);
		@(posedge clk);
		rst_n <= 1'b0;
		strap <= s;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		mac.rx_q.delete();
		mac.n_rx_er = 0;
	endtask : boot

	task automatic line(input pmpl_pkg::pmpl_sym_e s, input logic [3:0] d);
		@(posedge rx_clk);
		line_in <= '{s, d};
	endtask : line

	task automatic tail(input logic [3:0] q[$]);
		int base;
		base = mac.rx_q.size() - q.size();
		check(16'(base >= 0), 16'h0001);
		if (base >= 0) begin
			foreach (q[i]) check(16'(mac.rx_q[base + i]), 16'(q[i]));
		end
	endtask : tail

	task automatic rx_frame(input logic tr, input logic bad);
		line(pmpl_pkg::PMPL_SYM_JK, 4'h0);
		foreach (frm[i]) begin
			if (bad && i == 4) line(pmpl_pkg::PMPL_SYM_BAD, 4'h0);
			else line(pmpl_pkg::PMPL_SYM_DATA, frm[i]);
			if (i == 3) begin
				#1;
				check(16'(crs), 16'h0001);
			end
		end
		if (tr) line(pmpl_pkg::PMPL_SYM_TR, 4'h0);
		repeat (6) line(pmpl_pkg::PMPL_SYM_IDLE, 4'h0);
		#1;
	endtask : rx_frame

	////////////////////////////////////////////////////////////////////
	task automatic t_aneg();
		logic [15:0] v;
		for (int k = 0; k < 2; k++) begin
			p_aneg <= k[0];
			p_full <= 1'b1;
			boot(4'b0111);
			rd_reg(pmpl_pkg::PMPL_ADDR_CTRL, v);
			check(v, 16'h1000);
			rd_reg(pmpl_pkg::PMPL_ADDR_XOVER, v);
			check(v, 16'h0200);
			check(16'(mdix_auto), 16'h0001);
			rd_reg(4'hf, v);
			check(v, 16'h0000);
			repeat (1010) @(posedge clk);
			rd_reg(pmpl_pkg::PMPL_ADDR_STATUS, v);
			check(v & 16'h0007, k ? 16'h0004 : 16'h0001);
		end
		$display("test aneg done");
	endtask : t_aneg

	task automatic t_straps();
		logic [15:0] v;
		time         t0;
		for (int k = 0; k < 8; k++) begin
			// fiber has no 10 Mbps mode, so that pairing is skipped
			if (k == 0 || k == 2) continue;
			boot({1'b1, k[2], k[1], k[0]});
			rd_reg(pmpl_pkg::PMPL_ADDR_STATUS, v);
			check(v & 16'h000e, {12'h000, k[2], k[1], ~k[0], 1'b0});
			@(posedge tx_clk);
			t0 = $time;
			@(posedge tx_clk);
			check(16'(($time - t0) / 10), k[2] ? 16'h0004 : 16'h0028);
		end
		$display("test straps done");
	endtask : t_straps

	task automatic t_rx100();
		boot(4'b1111);
		rx_frame(1'b1, 1'b0);
		check(16'(crs), 16'h0000);
		tail(frm);
		check(16'(mac.n_rx_er), 16'h0000);
		boot(4'b1111);
		rx_frame(1'b0, 1'b1);
		check(16'(crs), 16'h0000);
		check(16'(mac.n_rx_er), 16'h0002);
		check(16'(mac.er_nib), 16'h000e);
		$display("test rx100 done");
	endtask : t_rx100

	task automatic t_tx100();
		boot(4'b1111);
		#1;
		check(16'(line_out.sym), 16'(pmpl_pkg::PMPL_SYM_IDLE));
		fork
			mac.send(frm, 1'b1);
			begin
				repeat (5) @(posedge tx_clk);
				#1;
				check(16'(line_out.sym), 16'(pmpl_pkg::PMPL_SYM_H));
				check(16'(crs), 16'h0000);
				check(16'(col), 16'h0000);
			end
		join
		$display("test tx100 done");
	endtask : t_tx100

	task automatic t_10m();
		logic [3:0] body[$] = {4'hd, 4'ha, 4'h3, 4'hc};
		boot(4'b1001);
		fork
			mac.send(frm, 1'b0);
			begin
				repeat (4) @(posedge tx_clk);
				#1;
				check(16'(crs), 16'h0001);
			end
		join
		repeat (8) @(posedge tx_clk);
		tail(frm);
		wr_reg(pmpl_pkg::PMPL_ADDR_CFG, 16'h0100);
		mac.rx_q.delete();
		mac.send(frm, 1'b0);
		repeat (8) @(posedge tx_clk);
		check(16'(mac.rx_q.size()), 16'h0000);
		fork
			mac.send(frm, 1'b0);
			begin
				repeat (5) line(pmpl_pkg::PMPL_SYM_DATA, 4'h5);
				#1;
				check(16'(col), 16'h0001);
				line(pmpl_pkg::PMPL_SYM_IDLE, 4'h0);
			end
		join
		// plain 10 Mbps receive: preamble stripped, valid from the sfd nibble
		mac.rx_q.delete();
		foreach (frm[i]) line(pmpl_pkg::PMPL_SYM_DATA, frm[i]);
		repeat (3) line(pmpl_pkg::PMPL_SYM_IDLE, 4'h0);
		#1;
		check(16'(mac.rx_q.size()), 16'h0004);
		tail(body);
		check(16'(crs), 16'h0000);
		$display("test 10m done");
	endtask : t_10m

	task automatic t_loop();
		logic [15:0] v;
		// straps off, so the control and config bits alone set the mode
		boot(4'b0111);
		wr_reg(pmpl_pkg::PMPL_ADDR_CFG, 16'h0001);
		wr_reg(pmpl_pkg::PMPL_ADDR_CTRL, 16'h6100);
		repeat (2) @(posedge clk);
		#1;
		check(16'(line_oe), 16'h0000);
		rd_reg(pmpl_pkg::PMPL_ADDR_STATUS, v);
		check(v & 16'h000e, 16'h000e);
		mac.send(frm, 1'b0);
		repeat (8) @(posedge tx_clk);
		tail(frm);
		wr_reg(pmpl_pkg::PMPL_ADDR_CTRL, 16'h7100);
		repeat (2) @(posedge clk);
		#1;
		check(16'(line_oe), 16'h0001);
		$display("test loop done");
	endtask : t_loop

	////////////////////////////////////////////////////////////////////
	initial begin
		t_aneg();
		t_straps();
		t_rx100();
		t_tx100();
		t_10m();
		t_loop();
		close_out();
	end

	// whole run is under 5,000 cycles; this span leaves wide margin
	initial begin
		#400000;
		n_errors++;
		$display("[ERR] %0t watchdog expired", $time);
		close_out();
	end
endmodule : testbench
